// File: logic/amew_error_word.sv
// error-word reporting block of an analog expansion module
`include "amew_map.svh"
`default_nettype none
module amew_error_word #(
  parameter int NCH = 4,
  parameter int DW = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire amew_pkg::amew_variant_e variant,
  input wire amew_pkg::amew_bus_req_s bus_req,
  output logic [15:0] rdata,
  input wire logic hw_fault_pin,
  input wire logic [NCH*DW-1:0] out_value,
  output logic [NCH*DW-1:0] out_drive,
  output logic [15:0] active_cfg,
  output logic irq
);
  import amew_pkg::*;

  logic hw_s1_q, hw_s2_q;
  amew_state_e st_q, st_d;
  amew_word_s word_q, word_d;
  logic [15:0] cfg_q, cfg_d;
  logic [1:0] stat_q, stat_d;
  logic [1:0] mask_q, mask_d;
  logic [15:0] rdata_q, rdata_d;
  logic [NCH*DW-1:0] drv_q, drv_d;
  logic cfg_bad;
  logic [8:0] cfg_code;
  logic cfg_wr;

  // a range of 2'b11 is unsupported except on AMEW_VAR_2IN2OUT; filter set only illegal on input variant
  function automatic logic [8:0] amew_check(input logic [15:0] c, input amew_variant_e v);
    amew_chan_cfg_s ch;
    logic [8:0] code;
    code = 9'h000;
    if (v == AMEW_VAR_2IN2OUT) begin
      // format bit 1 unsupported: ch0/1 input then ch0/1 output
      for (int i = NCH - 1; i >= 0; i--) begin
        ch = c[i*4 +: 4];
        if (ch.format) begin
          code = 9'(`AMEW_EXT_IFMT_BASE + 9'(i));
        end
      end
    end else begin
      for (int i = NCH - 1; i >= 0; i--) begin
        ch = c[i*4 +: 4];
        if (ch.format) begin
          code = 9'(`AMEW_EXT_FMT_BASE + 9'(i));
        end
      end
      if (v == AMEW_VAR_4IN) begin
        for (int i = NCH - 1; i >= 0; i--) begin
          ch = c[i*4 +: 4];
          if (ch.filter) begin
            code = 9'(`AMEW_EXT_FILTER_BASE + 9'(i));
          end
        end
      end
      for (int i = NCH - 1; i >= 0; i--) begin
        ch = c[i*4 +: 4];
        if (ch.range == 2'b11) begin
          code = 9'(`AMEW_EXT_RANGE_BASE + 9'(i));
        end
      end
    end
    if (v == AMEW_VAR_4OUT || v == AMEW_VAR_4IN || v == AMEW_VAR_2IN2OUT) begin
      return code;
    end
    return `AMEW_EXT_GENERAL;
  endfunction

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hw_s1_q <= 1'b0;
      hw_s2_q <= 1'b0;
    end else begin
      hw_s1_q <= hw_fault_pin;
      hw_s2_q <= hw_s1_q;
    end
  end

  assign cfg_wr = bus_req.wr && bus_req.addr == `AMEW_OFF_CFG;
  always_comb begin
    cfg_code = amew_check(bus_req.wdata, variant);
    cfg_bad = cfg_code != 9'h000;
    if (variant != AMEW_VAR_2IN2OUT && variant != AMEW_VAR_4IN && variant != AMEW_VAR_4OUT) begin
      cfg_bad = 1'b1;
    end
  end

  always_comb begin
    st_d = st_q;
    word_d = word_q;
    cfg_d = cfg_q;
    stat_d = stat_q;
    mask_d = mask_q;
    case (st_q)
      AMEW_ST_POWERUP: begin
        st_d = AMEW_ST_RUN;
        word_d = '{4'h0, `AMEW_TYPE_NONE, 9'h000};
      end
      AMEW_ST_RUN, AMEW_ST_FAULT: begin
        if (cfg_wr) begin
          if (cfg_bad) begin
            word_d = '{4'h0, `AMEW_TYPE_CFG, cfg_code};
            stat_d[`AMEW_IRQ_CFG_BIT] = 1'b1;
          end else begin
            cfg_d = bus_req.wdata;
            word_d = '{4'h0, `AMEW_TYPE_NONE, 9'h000};
          end
        end
        if (hw_s2_q) begin
          st_d = AMEW_ST_FAULT;
          word_d = '{4'h0, `AMEW_TYPE_HW, `AMEW_EXT_GENERAL};
        end else if (st_q == AMEW_ST_FAULT) begin
          st_d = AMEW_ST_RUN;
        end
      end
      default: begin
        st_d = AMEW_ST_POWERUP;
      end
    endcase
    if (bus_req.wr && bus_req.addr == `AMEW_OFF_IRQ_STAT) begin
      stat_d = stat_q & ~bus_req.wdata[1:0];
      if (cfg_wr && cfg_bad) begin
        stat_d[`AMEW_IRQ_CFG_BIT] = 1'b1;
      end
    end
    if (hw_s2_q) begin
      stat_d[`AMEW_IRQ_HW_BIT] = 1'b1;
    end
    if (bus_req.wr && bus_req.addr == `AMEW_OFF_IRQ_MASK) begin
      mask_d = bus_req.wdata[1:0];
    end
    // software clears a latched error word back to no-error
    if (bus_req.wr && bus_req.addr == `AMEW_OFF_CTRL && bus_req.wdata[0] && !hw_s2_q) begin
      word_d = '{4'h0, `AMEW_TYPE_NONE, 9'h000};
    end
    word_d.spare = 4'h0;
  end

  always_comb begin
    rdata_d = 16'h0000;
    if (bus_req.rd) begin
      if (bus_req.addr == `AMEW_OFF_ERR_WORD) begin
        rdata_d = word_q;
      end else if (bus_req.addr == `AMEW_OFF_CFG) begin
        rdata_d = cfg_q;
      end else if (bus_req.addr == `AMEW_OFF_ACTIVE_CFG) begin
        rdata_d = cfg_q;
      end else if (bus_req.addr == `AMEW_OFF_IRQ_STAT) begin
        rdata_d = {14'h0000, stat_q};
      end else if (bus_req.addr == `AMEW_OFF_IRQ_MASK) begin
        rdata_d = {14'h0000, mask_q};
      end else if (bus_req.addr == `AMEW_OFF_CTRL) begin
        rdata_d = {14'h0000, st_q};
      end else begin
        rdata_d = 16'h0000;
      end
    end
  end

  // outputs zero while any fault is reported
  always_comb begin
    if (word_q.err_type != `AMEW_TYPE_NONE || hw_s2_q || st_q != AMEW_ST_RUN) begin
      drv_d = '0;
    end else begin
      drv_d = out_value;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= AMEW_ST_POWERUP;
      word_q <= '{4'h0, `AMEW_TYPE_HW, `AMEW_EXT_POWERUP};
      cfg_q <= `AMEW_CFG_RESET;
      stat_q <= 2'b00;
      mask_q <= 2'b00;
      rdata_q <= 16'h0000;
      drv_q <= '0;
    end else begin
      st_q <= st_d;
      word_q <= word_d;
      cfg_q <= cfg_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      rdata_q <= rdata_d;
      drv_q <= drv_d;
    end
  end

  assign rdata = rdata_q;
  assign out_drive = drv_q;
  assign active_cfg = cfg_q;
  assign irq = |(stat_q & mask_q);
endmodule
`default_nettype wire

// File: shared/amew_map.svh
// offsets, field positions, codes and reset values of the error-word block
`ifndef AMEW_MAP_SVH
`define AMEW_MAP_SVH
`define AMEW_OFF_ERR_WORD 4'h0
`define AMEW_OFF_CFG 4'h1
`define AMEW_OFF_ACTIVE_CFG 4'h2
`define AMEW_OFF_IRQ_STAT 4'h3
`define AMEW_OFF_IRQ_MASK 4'h4
`define AMEW_OFF_CTRL 4'h5
`define AMEW_TYPE_LSB 9
`define AMEW_TYPE_MSB 11
`define AMEW_EXT_MSB 8
`define AMEW_TYPE_NONE 3'h0
`define AMEW_TYPE_HW 3'h1
`define AMEW_TYPE_CFG 3'h2
`define AMEW_EXT_GENERAL 9'h000
`define AMEW_EXT_POWERUP 9'h001
`define AMEW_EXT_RANGE_BASE 9'h001
`define AMEW_EXT_FILTER_BASE 9'h005
`define AMEW_EXT_FMT_BASE 9'h009
`define AMEW_EXT_IFMT_BASE 9'h001
`define AMEW_EXT_OFMT_BASE 9'h003
`define AMEW_CFG_RESET 16'h0000
`define AMEW_IRQ_CFG_BIT 0
`define AMEW_IRQ_HW_BIT 1
`endif

// File: shared/amew_pkg.sv
// types shared by the error-word block
`default_nettype none
package amew_pkg;
  typedef enum logic [1:0] {
    AMEW_VAR_2IN2OUT = 2'b00,
    AMEW_VAR_4IN = 2'b01,
    AMEW_VAR_4OUT = 2'b10
  } amew_variant_e;
  typedef enum logic [1:0] {
    AMEW_ST_POWERUP = 2'b00,
    AMEW_ST_RUN = 2'b01,
    AMEW_ST_FAULT = 2'b10
  } amew_state_e;
  typedef struct packed {
    logic [3:0] spare;
    logic [2:0] err_type;
    logic [8:0] ext_code;
  } amew_word_s;
  // one 4-bit channel config: [3:2] range, [1] filter, [0] format (per channel)
  typedef struct packed {
    logic [1:0] range;
    logic filter;
    logic format;
  } amew_chan_cfg_s;
  typedef struct packed {
    logic [3:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } amew_bus_req_s;
endpackage
`default_nettype wire

// File: tb/amew_error_word_monitor.sv
// port assertions for the error-word block
`default_nettype none
module amew_error_word_monitor #(
  parameter int NCH = 4,
  parameter int DW = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire amew_pkg::amew_bus_req_s bus_req,
  input wire logic [15:0] rdata,
  input wire logic hw_fault_pin,
  input wire logic [NCH*DW-1:0] out_drive,
  input wire logic [15:0] active_cfg
);
  import amew_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  wire rd0 = bus_req.rd && bus_req.addr == 4'h0;
  spare_zero_a: assert property (
    rd0 |=> rdata[15:12] == 4'h0) else $error("spare bits set");
  ext_clear_a: assert property (
    rd0 |=> rdata[11:9] != 3'h0 || rdata[8:0] == 9'h000) else $error("code without type");
  type_legal_a: assert property (
    rd0 |=> rdata[11:9] inside {3'h0, 3'h1, 3'h2}) else $error("bad type");
  hw_code_a: assert property (
    hw_fault_pin [*5] ##0 rd0 |=> rdata == 16'h0200) else $error("bad fault word");
  fault_out_a: assert property (
    hw_fault_pin [*4] |=> out_drive == '0) else $error("outputs live in fault");
  cfg_keep_a: assert property (
    bus_req.wr && bus_req.addr == 4'h1 && bus_req.wdata[0] |=> $stable(active_cfg))
    else $error("bad config taken");
  unmapped_a: assert property (
    bus_req.rd && bus_req.addr > 4'h5 |=> rdata == 16'h0000) else $error("unmapped read");
  idle_rd_a: assert property (
    !bus_req.rd |=> rdata == 16'h0000) else $error("read data held");
endmodule
bind amew_error_word amew_error_word_monitor #(.NCH(NCH), .DW(DW)) amew_error_word_monitor_i (
  .mclk(mclk), .rst_n(rst_n), .bus_req(bus_req), .rdata(rdata),
  .hw_fault_pin(hw_fault_pin), .out_drive(out_drive), .active_cfg(active_cfg));
`default_nettype wire

// File: tb/amew_host_model.sv
// host model: register bus master
`default_nettype none
module amew_host_model (
  input wire logic mclk,
  input wire logic [15:0] rdata,
  output var amew_pkg::amew_bus_req_s bus_req
);
  import amew_pkg::*;
  initial bus_req = '0;
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge mclk);
    bus_req <= '0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge mclk);
    bus_req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge mclk);
    bus_req <= '0;
    @(negedge mclk);
    d = rdata;
  endtask
endmodule
`default_nettype wire

// File: tb/tb_amew_error_word.sv
// testbench of the error-word block
`default_nettype none
module tb_amew_error_word;
  timeunit 1ns;
  timeprecision 1ns;
  import amew_pkg::*;
  logic mclk = 1'b0, rst_n = 1'b0, fault = 1'b0, irq;
  amew_variant_e var_sel = AMEW_VAR_4IN;
  logic [63:0] val = 64'h0, drv;
  logic [15:0] rdata, acfg, w;
  amew_bus_req_s req;
  int err_total = 0, checked = 0;
  // {variant, config, expected word}
  logic [33:0] tab [9] = '{{2'h1, 16'h000C, 16'h0401}, {2'h1, 16'h0020, 16'h0406},
    {2'h1, 16'h1000, 16'h040C}, {2'h1, 16'h0C01, 16'h0403}, {2'h2, 16'h0002, 16'h0000},
    {2'h2, 16'h0010, 16'h040A}, {2'h0, 16'h0100, 16'h0403}, {2'h0, 16'h0001, 16'h0401},
    {2'h3, 16'h0000, 16'h0400}};
  amew_error_word amew_error_word_i (.mclk(mclk), .rst_n(rst_n), .variant(var_sel),
    .bus_req(req), .rdata(rdata), .hw_fault_pin(fault), .out_value(val), .out_drive(drv),
    .active_cfg(acfg), .irq(irq));
  amew_host_model host (.mclk(mclk), .rdata(rdata), .bus_req(req));
  initial forever #5 mclk = ~mclk;
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic test_done();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic t_cfg();
    host.wr(4, 16'h0001);
    foreach (tab[i]) begin
      @(posedge mclk) var_sel <= amew_variant_e'(tab[i][33:32]);
      host.wr(1, 16'h0000);
      host.wr(1, tab[i][31:16]);
      host.rd(0, w);
      chk(w, tab[i][15:0]);
      chk(acfg, tab[i][15:0] != 0 ? 16'h0 : tab[i][31:16]);
      chk(irq, tab[i][15:0] != 0);
      host.wr(3, 16'h0001);
      host.rd(3, w);
      chk({irq, w[0]}, 0);
    end
  endtask
  task automatic t_hw();
    @(posedge mclk) var_sel <= AMEW_VAR_4IN;
    val <= 64'h1234_5678_9ABC_DEF0;
    host.wr(5, 16'h0001);
    host.rd(0, w);
    chk({w, drv}, {16'h0, val});
    @(posedge mclk) fault <= 1'b1;
    repeat (5) @(posedge mclk);
    host.rd(4'h0, w);
    chk({w, drv}, {16'h0200, 64'h0});
    host.rd(4'h5, w);
    chk(w, 16'h0002);
    @(posedge mclk) fault <= 1'b0;
    repeat (4) @(posedge mclk);
    host.wr(5, 16'h0001);
    host.rd(0, w);
    chk({w, drv}, {16'h0, val});
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst_n <= 1'b1;
    host.rd(0, w);
    chk(w, 16'h0000);
    t_cfg();
    t_hw();
    test_done();
  end
  initial begin
    #20us;
    err_total++;
    test_done();
  end
endmodule
`default_nettype wire
